// ---- logic/orf_top.sv ----
// Purpose: Serial settings registers with one-time fuse storage
// Assumes: Serial link mode 0, link pins asynchronous to core clock
// Notes:   Fuse array supplies image and burned flags at reset release
//
// What this block does
// - Select bit n burns register n into fuses
// - Burned value reloads at every power-up
// - Writes to burned registers are ignored
// - Unburned registers work from written values
// - Zero position is twelve bits per turn
// - Register 4 holds zero position top eight
// - Register 5 low nibble holds bottom four
// - Read answers angle byte then register byte
// - Reversal with channels differing adds one edge
// - Reversal with equal channels adds no edge
// - Write frame is 0010, address, value
// - Read frame is 0001, address, don't-care
// - Start-up copies fuses, else zero
`include "orf_defines.svh"
`default_nettype none

module orf_top #(
  parameter int BURN_CYCLES = `ORF_BURN_CYCLES
) (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_reset_n,
  input  wire logic                   i_clk_en,
  input  wire logic [15:0]            i_angle,
  input  wire logic                   i_spi_sclk,
  input  wire logic                   i_spi_cs_n,
  input  wire logic                   i_spi_mosi,
  input  wire logic                   i_fuse_program_supply_pin,
  input  wire orf_pkg::orf_fuse_img_s i_fuse_img,
  output var  logic                   o_spi_miso,
  output var  logic                   o_spi_miso_oe,
  output var  orf_pkg::orf_fuse_prog_s o_fuse_prog,
  output var  orf_pkg::orf_abz_s      o_abz
);
  import orf_pkg::*;

  // Burn counter is 16 bits wide and needs at least one cycle
  if (BURN_CYCLES < 1 || BURN_CYCLES > 65535) begin : g_bad_burn
    $error("BURN_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: sclk, cs_n, mosi, supply
  logic [3:0] pin_raw;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] sync3_q;
  logic [3:0] lvl_q;
  logic [3:0] lvl_d;

  assign pin_raw = {i_fuse_program_supply_pin, i_spi_mosi, i_spi_cs_n,
                    i_spi_sclk};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_comb begin
        lvl_d[gi] = (sync2_q[gi] == sync3_q[gi]) ? sync3_q[gi] : lvl_q[gi];
      end
      always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          // Select starts at its idle level: no false frame after reset
          sync1_q[gi] <= (gi == 1);
          sync2_q[gi] <= (gi == 1);
          sync3_q[gi] <= (gi == 1);
          lvl_q[gi]   <= (gi == 1);
        end else if (i_clk_en) begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          lvl_q[gi]   <= lvl_d[gi];
        end
      end
    end
  endgenerate

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_active;
  logic supply_on;

  always_comb begin
    sclk_rise = lvl_d[0] & ~lvl_q[0];
    sclk_fall = ~lvl_d[0] & lvl_q[0];
    cs_fall   = ~lvl_d[1] & lvl_q[1];
    cs_active = ~lvl_q[1];
    supply_on = lvl_q[3];
  end

  ////////////////////////////////////////////////////////////////////////
  // Settings, lock flags, burn sequencer and serial frame
  orf_state_e     st_q;
  orf_state_e     st_d;
  logic [7:0]     zero_high_q;
  logic [7:0]     zero_high_d;
  logic [7:0]     zero_low_q;
  logic [7:0]     zero_low_d;
  logic [1:0]     lock_q;
  logic [1:0]     lock_d;
  logic [7:0]     burn_sel_q;
  logic [7:0]     burn_sel_d;
  logic [15:0]    burn_cnt_q;
  logic [15:0]    burn_cnt_d;
  orf_fuse_prog_s prog_q;
  orf_fuse_prog_s prog_d;
  logic [15:0]    rx_q;
  logic [15:0]    rx_d;
  logic [15:0]    tx_q;
  logic [15:0]    tx_d;
  logic [4:0]     rise_cnt_q;
  logic [4:0]     rise_cnt_d;
  logic [4:0]     fall_cnt_q;
  logic [4:0]     fall_cnt_d;
  logic           miso_q;
  logic           miso_d;
  logic           miso_oe_q;
  logic           miso_oe_d;
  logic [15:0]    angle_out;
  logic [11:0]    zero_pos;
  logic [7:0]     rd_data;
  logic [3:0]     burn_idx;
  logic           burn_onehot;

  always_comb begin
    zero_pos  = {zero_high_q, zero_low_q[3:0]};
    angle_out = i_angle - {zero_pos, 4'h0};
    unique case (rx_d[3:0])
      `ORF_ADDR_ZERO_HIGH: rd_data = zero_high_q;
      `ORF_ADDR_ZERO_LOW:  rd_data = zero_low_q;
      default:             rd_data = `ORF_REG_RESET;
    endcase
    burn_onehot = (burn_sel_q != 8'h00) &&
                  ((burn_sel_q & (burn_sel_q - 8'h01)) == 8'h00);
    burn_idx = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (burn_sel_q[i]) begin
        burn_idx = 4'(i);
      end
    end
  end

  always_comb begin
    st_d        = st_q;
    zero_high_d = zero_high_q;
    zero_low_d  = zero_low_q;
    lock_d      = lock_q;
    burn_sel_d  = burn_sel_q;
    burn_cnt_d  = burn_cnt_q;
    prog_d      = prog_q;
    rx_d        = rx_q;
    tx_d        = tx_q;
    rise_cnt_d  = rise_cnt_q;
    fall_cnt_d  = fall_cnt_q;
    miso_oe_d   = cs_active;
    miso_d      = miso_q;

    // Serial frame, mode 0, MSB first
    if (cs_fall) begin
      tx_d       = angle_out;
      rise_cnt_d = 5'h00;
      fall_cnt_d = 5'h00;
      miso_d     = angle_out[15];
    end else if (cs_active) begin
      if (sclk_rise && rise_cnt_q < `ORF_FRAME_BITS) begin
        rx_d       = {rx_q[14:0], lvl_q[2]};
        rise_cnt_d = rise_cnt_q + 5'h01;
        if (rise_cnt_d == `ORF_BYTE_BITS &&
            rx_d[7:4] == `ORF_CMD_READ) begin
          tx_d[7:0] = rd_data;
        end
        if (rise_cnt_d == `ORF_FRAME_BITS &&
            rx_d[15:12] == `ORF_CMD_WRITE) begin
          unique case (rx_d[11:8])
            `ORF_ADDR_ZERO_HIGH: begin
              if (!lock_q[0]) begin
                zero_high_d = rx_d[7:0];
              end
            end
            `ORF_ADDR_ZERO_LOW: begin
              if (!lock_q[1]) begin
                zero_low_d = rx_d[7:0];
              end
            end
            `ORF_ADDR_BURN_SEL: begin
              if (st_q == ORF_ST_RUN) begin
                burn_sel_d = rx_d[7:0];
              end
            end
            default: begin
            end
          endcase
        end
      end
      if (sclk_fall && fall_cnt_q < `ORF_FRAME_BITS) begin
        fall_cnt_d = fall_cnt_q + 5'h01;
        miso_d     = (fall_cnt_d < `ORF_FRAME_BITS) ?
                     tx_d[4'hF - fall_cnt_d[3:0]] : 1'b0;
      end
    end

    // Start-up load and fuse burning
    unique case (st_q)
      ORF_ST_LOAD: begin
        zero_high_d = i_fuse_img.burned[0] ? i_fuse_img.data_high
                                           : `ORF_REG_RESET;
        zero_low_d  = i_fuse_img.burned[1] ? i_fuse_img.data_low
                                           : `ORF_REG_RESET;
        lock_d      = i_fuse_img.burned;
        st_d        = ORF_ST_RUN;
      end
      ORF_ST_RUN: begin
        if (burn_sel_q != 8'h00) begin
          burn_sel_d = 8'h00;
          if (burn_onehot && supply_on &&
              ((burn_idx == `ORF_ADDR_ZERO_HIGH && !lock_q[0]) ||
               (burn_idx == `ORF_ADDR_ZERO_LOW && !lock_q[1]))) begin
            prog_d.enable = 1'b1;
            prog_d.addr   = burn_idx;
            prog_d.data   = (burn_idx == `ORF_ADDR_ZERO_HIGH) ?
                            zero_high_q : zero_low_q;
            burn_cnt_d    = 16'(BURN_CYCLES - 1);
            st_d          = ORF_ST_BURN;
          end
        end
      end
      ORF_ST_BURN: begin
        if (burn_cnt_q == 16'h0000) begin
          prog_d.enable = 1'b0;
          if (prog_q.addr == `ORF_ADDR_ZERO_HIGH) begin
            lock_d[0] = 1'b1;
          end else begin
            lock_d[1] = 1'b1;
          end
          st_d = ORF_ST_RUN;
        end else begin
          burn_cnt_d = burn_cnt_q - 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q        <= ORF_ST_LOAD;
      zero_high_q <= `ORF_REG_RESET;
      zero_low_q  <= `ORF_REG_RESET;
      lock_q      <= 2'b00;
      burn_sel_q  <= 8'h00;
      burn_cnt_q  <= 16'h0000;
      prog_q      <= '0;
      rx_q        <= 16'h0000;
      tx_q        <= 16'h0000;
      rise_cnt_q  <= 5'h00;
      fall_cnt_q  <= 5'h00;
      miso_q      <= 1'b0;
      miso_oe_q   <= 1'b0;
    end else if (i_clk_en) begin
      st_q        <= st_d;
      zero_high_q <= zero_high_d;
      zero_low_q  <= zero_low_d;
      lock_q      <= lock_d;
      burn_sel_q  <= burn_sel_d;
      burn_cnt_q  <= burn_cnt_d;
      prog_q      <= prog_d;
      rx_q        <= rx_d;
      tx_q        <= tx_d;
      rise_cnt_q  <= rise_cnt_d;
      fall_cnt_q  <= fall_cnt_d;
      miso_q      <= miso_d;
      miso_oe_q   <= miso_oe_d;
    end
  end

  assign o_spi_miso    = miso_q;
  assign o_spi_miso_oe = miso_oe_q;
  assign o_fuse_prog   = prog_q;

  ////////////////////////////////////////////////////////////////////////
  // Incremental output, 1024 edges per turn
  orf_abz u_abz (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_clk_en   (i_clk_en),
    .i_pos      (angle_out[15:6]),
    .o_abz      (o_abz)
  );

endmodule

`default_nettype wire

// ---- include/orf_defines.svh ----
// Purpose: Constants of the fuse-backed settings block
// Assumes: 100 MHz core clock
// Notes:   Offsets are register addresses on the serial link
`ifndef ORF_DEFINES_SVH
`define ORF_DEFINES_SVH

`define ORF_CLK_MHZ         100
`define ORF_BURN_TIME_NS    10000
`define ORF_BURN_CYCLES     ((`ORF_BURN_TIME_NS * `ORF_CLK_MHZ + 999) / 1000)

`define ORF_ADDR_ZERO_HIGH  4'h4
`define ORF_ADDR_ZERO_LOW   4'h5
`define ORF_ADDR_BURN_SEL   4'h9

`define ORF_CMD_READ        4'h1
`define ORF_CMD_WRITE       4'h2

`define ORF_REG_RESET       8'h00
`define ORF_FRAME_BITS      5'h10
`define ORF_BYTE_BITS       5'h08
`define ORF_ZERO_LSB        4

`define ORF_ABZ_HALF_TURN   10'h200

`endif

// ---- include/orf_pkg.sv ----
// Purpose: Types of the fuse-backed settings block
// Assumes: Nothing
// Notes:   Constants live in orf_defines.svh
`default_nettype none

package orf_pkg;

  typedef enum logic [1:0] {
    ORF_ST_LOAD = 2'b00,
    ORF_ST_RUN  = 2'b01,
    ORF_ST_BURN = 2'b11
  } orf_state_e;

  // Image delivered by the fuse array
  typedef struct packed {
    logic [1:0] burned;   // [0] zero high, [1] zero low
    logic [7:0] data_high;
    logic [7:0] data_low;
  } orf_fuse_img_s;

  // Programming request towards the fuse array
  typedef struct packed {
    logic       enable;
    logic [3:0] addr;
    logic [7:0] data;
  } orf_fuse_prog_s;

  typedef struct packed {
    logic a;
    logic b;
    logic z;
  } orf_abz_s;

endpackage

`default_nettype wire

// ---- logic/orf_abz.sv ----
// Purpose: Quadrature A/B/Z generator from a 10-bit position
// Assumes: Position moves at most a few steps per cycle
// Notes:   Reproduces the extra edge on reversal with A and B differing
`default_nettype none

module orf_abz (
  input  wire logic              i_core_clk,
  input  wire logic              i_reset_n,
  input  wire logic              i_clk_en,
  input  wire logic [9:0]        i_pos,
  output var  orf_pkg::orf_abz_s o_abz
);
  import orf_pkg::*;

  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  logic [9:0] off_q;
  logic [9:0] off_d;
  logic       dir_up_q;
  logic       dir_up_d;
  orf_abz_s   abz_q;
  orf_abz_s   abz_d;
  logic [9:0] target;
  logic [9:0] diff;
  logic       step_up;
  logic [9:0] old_step;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    target   = i_pos + off_q;
    diff     = target - cnt_q;
    step_up  = (diff < `ORF_ABZ_HALF_TURN);
    old_step = dir_up_q ? 10'h001 : 10'h3FF;
    cnt_d    = cnt_q;
    off_d    = off_q;
    dir_up_d = dir_up_q;
    if (diff != 10'h000) begin
      if ((step_up != dir_up_q) && cnt_q[0]) begin
        // Reversal with channels differing: one more old-way step
        cnt_d = cnt_q + old_step;
        off_d = off_q + old_step;
      end else begin
        // Same levels on reversal: plain step, no extra edge
        cnt_d = step_up ? cnt_q + 10'h001 : cnt_q - 10'h001;
      end
      dir_up_d = step_up;
    end
    abz_d.a = cnt_d[1] ^ cnt_d[0];
    abz_d.b = cnt_d[1];
    abz_d.z = (cnt_d == 10'h000);
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q    <= 10'h000;
      off_q    <= 10'h000;
      dir_up_q <= 1'b1;
      abz_q    <= '0;
    end else if (i_clk_en) begin
      cnt_q    <= cnt_d;
      off_q    <= off_d;
      dir_up_q <= dir_up_d;
      abz_q    <= abz_d;
    end
  end

  assign o_abz = abz_q;

endmodule

`default_nettype wire

// ---- sim/orf_top_checker.sv ----
// Purpose: Port checks of the fuse-backed settings block
// Assumes: Clock enable held high
// Notes:   Bound to orf_top at the foot of this file
`include "orf_defines.svh"
`default_nettype none

module orf_top_checker #(
  parameter int BURN_CYCLES = `ORF_BURN_CYCLES
) (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_reset_n,
  input  wire logic                    i_spi_cs_n,
  input  wire logic                    i_fuse_program_supply_pin,
  input  wire orf_pkg::orf_fuse_img_s  i_fuse_img,
  input  wire logic                    o_spi_miso_oe,
  input  wire orf_pkg::orf_fuse_prog_s o_fuse_prog,
  input  wire orf_pkg::orf_abz_s       o_abz
);
  import orf_pkg::*;
  logic [15:0] len_d;
  logic [15:0] len_q;
  logic [1:0]  lock_d;
  logic [1:0]  lock_q;
  logic [1:0]  lk;
  logic        hit;

  // Burn length and registers already burned
  always_comb begin
    len_d = o_fuse_prog.enable ? len_q + 16'h0001 : 16'h0000;
    lock_d = lock_q | ({2{o_fuse_prog.enable}} &
      {o_fuse_prog.addr == 4'h5, o_fuse_prog.addr == 4'h4});
    lk = lock_q | i_fuse_img.burned;
    hit = (o_fuse_prog.addr == 4'h4) ? lk[0] : lk[1];
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      len_q  <= 16'h0000;
      lock_q <= 2'b00;
    end else begin
      len_q  <= len_d;
      lock_q <= lock_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  burn_supply_a: assert property (
    $rose(o_fuse_prog.enable) |-> i_fuse_program_supply_pin)
    else $error("burn started without supply");
  burn_len_a: assert property (
    $fell(o_fuse_prog.enable) |-> len_q == BURN_CYCLES)
    else $error("burn length wrong");
  burn_addr_a: assert property (
    o_fuse_prog.enable |-> o_fuse_prog.addr inside {4'h4, 4'h5})
    else $error("burn of unknown register");
  burn_hold_a: assert property (
    o_fuse_prog.enable && $past(o_fuse_prog.enable) |->
      $stable(o_fuse_prog.addr) && $stable(o_fuse_prog.data))
    else $error("burn request moved");
  burn_lock_a: assert property (
    $rose(o_fuse_prog.enable) |-> !hit)
    else $error("burned register burned again");
  oe_on_a: assert property (
    $fell(i_spi_cs_n) |-> ##[3:6] o_spi_miso_oe)
    else $error("miso not driven after select");
  oe_off_a: assert property (
    $rose(i_spi_cs_n) |-> ##[3:6] !o_spi_miso_oe)
    else $error("miso still driven after deselect");
  quad_step_a: assert property (
    $changed(o_abz.a) |-> $stable(o_abz.b))
    else $error("both quadrature channels moved");

  burn_seen_c: cover property ($rose(o_fuse_prog.enable));
  frame_seen_c: cover property ($fell(i_spi_cs_n));
  quad_seen_c: cover property ($changed(o_abz.a));
endmodule

bind orf_top orf_top_checker #(
  .BURN_CYCLES(BURN_CYCLES)
) u_checker (
  .i_core_clk               (i_core_clk),
  .i_reset_n                (i_reset_n),
  .i_spi_cs_n               (i_spi_cs_n),
  .i_fuse_program_supply_pin(i_fuse_program_supply_pin),
  .i_fuse_img               (i_fuse_img),
  .o_spi_miso_oe            (o_spi_miso_oe),
  .o_fuse_prog              (o_fuse_prog),
  .o_abz                    (o_abz)
);

`default_nettype wire

// ---- sim/orf_spi_master.sv ----
// Purpose: Serial master, mode 0, 80 ns link clock
// Assumes: Core needs about five cycles to answer a link edge
// Notes:   Bits taken late in the high phase for that reason
`default_nettype none

module orf_spi_master (
  input  wire logic i_miso,
  output var  logic o_sclk,
  output var  logic o_cs_n,
  output var  logic o_mosi
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b1;
  end

  // Link clock idles low outside frames
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    #3 o_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      o_mosi = tx[i];
      #40 o_sclk = 1'b1;
      #40 rx[i] = i_miso;
      o_sclk = 1'b0;
    end
    #40 o_cs_n = 1'b1;
    o_mosi = ~tx[0];
    #80;
  endtask
endmodule

`default_nettype wire

// ---- sim/orf_top_tb.sv ----
// Purpose: Self-checking bench of the fuse-backed settings block
// Assumes: Short burn through BURN_CYCLES
// Notes:   Fuse array kept here; power cycle reloads its image
`include "orf_defines.svh"
`default_nettype none

`define CHK(what, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("unexpected %s: expected %h, seen %h", what, exp, got); \
    end \
  end

module orf_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import orf_pkg::*;
  localparam int          BURN  = 4;
  localparam int          LIMIT = 20000;
  localparam logic [15:0] ANGLE = 16'hA5C3;
  logic [15:0]    angle      = ANGLE;
  logic           i_core_clk = 1'b0;
  logic           i_reset_n  = 1'b0;
  logic           supply     = 1'b0;
  orf_fuse_img_s  img        = '0;
  orf_fuse_img_s  fuses      = '0;
  logic           sclk;
  logic           cs_n;
  logic           mosi;
  logic           miso;
  logic           miso_oe;
  logic           prog_q     = 1'b0;
  orf_fuse_prog_s prog;
  orf_abz_s       abz;
  logic [15:0]    rx;
  int             err_count   = 0;
  int             comparisons = 0;
  int             burns       = 0;
  int             cycles      = 0;
  logic [1:0]     ph_q        = 2'b00;
  logic [1:0]     ph;
  int             qpos        = 0;

  always #5 i_core_clk = ~i_core_clk;

  orf_top #(.BURN_CYCLES(BURN)) dut (
    .i_core_clk               (i_core_clk),
    .i_reset_n                (i_reset_n),
    .i_clk_en                 (1'b1),
    .i_angle                  (angle),
    .i_spi_sclk               (sclk),
    .i_spi_cs_n               (cs_n),
    .i_spi_mosi               (mosi),
    .i_fuse_program_supply_pin(supply),
    .i_fuse_img               (img),
    .o_spi_miso               (miso),
    .o_spi_miso_oe            (miso_oe),
    .o_fuse_prog              (prog),
    .o_abz                    (abz)
  );

  // Released miso line shows a changing pattern
  orf_spi_master master (
    .i_miso(miso_oe ? miso : cycles[0]),
    .o_sclk(sclk),
    .o_cs_n(cs_n),
    .o_mosi(mosi)
  );

  ////////////////////////////////////////////////////////////////////////
  // Fuse array: records each burn request
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    prog_q <= prog.enable;
    if (prog.enable === 1'b1 && prog_q !== 1'b1) begin
      burns <= burns + 1;
      if (prog.addr === `ORF_ADDR_ZERO_HIGH) begin
        fuses.burned[0] <= 1'b1;
        fuses.data_high <= prog.data;
      end else begin
        fuses.burned[1] <= 1'b1;
        fuses.data_low  <= prog.data;
      end
    end
  end

  always @(posedge i_core_clk) begin
    if (cycles == LIMIT) begin
      err_count = err_count + 1;
      results();
    end
  end

  // Quadrature decoder: phase is {b, a^b}, counts edges up or down
  assign ph = {abz.b, abz.a ^ abz.b};
  always @(posedge i_core_clk) begin
    ph_q <= ph;
    if (ph == ph_q + 2'b01) begin
      qpos <= qpos + 1;
    end else if (ph == ph_q - 2'b01) begin
      qpos <= qpos - 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge i_core_clk);
    i_reset_n <= 1'b0;
    repeat (20) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    repeat (8) @(posedge i_core_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    master.xfer({`ORF_CMD_WRITE, a, v}, rx);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] v,
                    input logic [11:0] z);
    logic [15:0] w;
    w = ANGLE - {z, 4'h0};
    master.xfer({`ORF_CMD_READ, a, 8'h00}, rx);
    `CHK("angle byte", w[15:8], rx[15:8])
    `CHK("register byte", v, rx[7:0])
  endtask

  task automatic burn(input logic [7:0] sel, input int n);
    wr(`ORF_ADDR_BURN_SEL, sel);
    repeat (BURN + 20) @(posedge i_core_clk);
    `CHK("burn count", n, burns)
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_start();
    rd(`ORF_ADDR_ZERO_HIGH, 8'h00, 12'h000);
    rd(`ORF_ADDR_ZERO_LOW, 8'h00, 12'h000);
    rd(`ORF_ADDR_BURN_SEL, 8'h00, 12'h000);
    master.xfer(16'h0000, rx);
    `CHK("angle word", ANGLE, rx)
    $display("t_start done");
  endtask

  task automatic t_settings();
    wr(`ORF_ADDR_ZERO_HIGH, 8'h23);
    wr(`ORF_ADDR_ZERO_LOW, 8'h08);
    rd(`ORF_ADDR_ZERO_HIGH, 8'h23, 12'h238);
    rd(`ORF_ADDR_ZERO_LOW, 8'h08, 12'h238);
    wr(`ORF_ADDR_ZERO_LOW, 8'hF8);
    rd(`ORF_ADDR_ZERO_LOW, 8'hF8, 12'h238);
    wr(`ORF_ADDR_ZERO_LOW, 8'h08);
    wr(4'h3, 8'h77);
    rd(4'h3, 8'h00, 12'h238);
    master.xfer(16'h0000, rx);
    `CHK("angle word", ANGLE - 16'h2380, rx)
    $display("t_settings done");
  endtask

  task automatic t_burn();
    burn(8'h10, 0);
    supply <= 1'b1;
    repeat (10) @(posedge i_core_clk);
    burn(8'h30, 0);
    burn(8'h10, 1);
    `CHK("burned high", 8'h23, fuses.data_high)
    wr(`ORF_ADDR_ZERO_HIGH, 8'h55);
    rd(`ORF_ADDR_ZERO_HIGH, 8'h23, 12'h238);
    burn(8'h20, 2);
    `CHK("burned low", 8'h08, fuses.data_low)
    burn(8'h10, 2);
    supply <= 1'b0;
    $display("t_burn done");
  endtask

  task automatic t_power();
    @(posedge i_core_clk);
    img <= fuses;
    do_reset();
    rd(`ORF_ADDR_ZERO_HIGH, 8'h23, 12'h238);
    rd(`ORF_ADDR_ZERO_LOW, 8'h08, 12'h238);
    wr(`ORF_ADDR_ZERO_LOW, 8'h0F);
    rd(`ORF_ADDR_ZERO_LOW, 8'h08, 12'h238);
    $display("t_power done");
  endtask

  // Zero stays 0x238 from fuses; position = (angle - 0x2380) >> 6
  task automatic t_abz();
    int base;
    @(posedge i_core_clk);
    angle <= 16'h2480;
    do_reset();
    repeat (20) @(posedge i_core_clk);
    base = qpos;
    angle <= 16'h2540;
    repeat (20) @(posedge i_core_clk);
    `CHK("abz forward", 3, qpos - base)
    angle <= 16'h24C0;
    repeat (20) @(posedge i_core_clk);
    `CHK("abz reversal odd", 2, qpos - base)
    angle <= 16'h2540;
    repeat (20) @(posedge i_core_clk);
    `CHK("abz reversal even", 4, qpos - base)
    $display("t_abz done");
  endtask

  initial begin
    do_reset();
    t_start();
    t_settings();
    t_burn();
    t_power();
    t_abz();
    results();
  end
endmodule

`default_nettype wire
